/* File: fes_cpu_model.sv */
// CPU core model: drives the bus address and one-cycle events.
// Assumes the bench pulses go for one cycle per event.
module fes_cpu_model import fes_pkg::*; (
  input wire logic clk,
  input wire logic go,
  input wire logic [23:0] addr,
  input wire logic [5:0] kind,
  output logic [23:0] cpu_addr,
  output fes_pkg::fes_event_s evt
);
  // Address follows, events pulse once
  always_ff @(posedge clk) begin
    cpu_addr <= addr;
    evt <= go ? kind : 6'h00;
  end
endmodule

/* File: fes_flash_ctrl.sv */
// Erase-block select, RAM overlay and flash error flag.
// Assumes single clock, synchronous inputs, byte-wide register port.
// Operation
// - Erase select clears on reset, standby, no enable
// - Only selected block may be erased
// - Erase bits ignored while soft enable zero
// - Mode 6 keeps erase bits zero
// - Decode eight erase blocks by address
// - Emulation bits 7-4 and 0 read one
// - Emulation bits zero outside modes 5-7
// - Emulation bits clear reset, hold soft standby
// - Emulation enable protects all flash blocks
// - Emulation maps RAM window onto flash
// - Error flag forces error protection
// - Error flag clears watchdog, pin reset, hardware standby
// - Flash read during program/erase sets error
// - Exception during program/erase sets error
// - Sleep during program/erase sets error
// - Bus release during program/erase sets error
// - Status bits 6-0 read one
// - Soft enable settable only with pin high
//
// Implementation choices: the strobed register port and the register offsets.
module fes_flash_ctrl #(
  parameter int ABITS = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire fes_pkg::fes_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire logic write_enable_pin,
  input wire logic [2:0] op_mode,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire fes_pkg::fes_event_s evt,
  input wire logic [ABITS-1:0] cpu_addr,
  output logic [ABITS-1:0] mapped_addr,
  output logic ram_overlay_hit,
  output logic [7:0] block_sel,
  output logic [7:0] erase_allow,
  output logic program_allow
);
  import fes_pkg::*;

  logic [7:0] flash_control_reg_ff;
  logic [7:0] erase_block_select_ff;
  logic [2:0] emu_bits_ff;
  logic flash_error_flag_ff;
  logic [7:0] reg_rdata_ff;
  logic [7:0] block_erase_bits;
  logic soft_write_enable;
  logic emu_map_enable;
  logic emu_mode_ok;
  logic pe_active;
  logic ram_hit;
  logic flash_hit;
  logic protect_all;
  logic wr_ctrl;
  logic wr_ebs;
  logic wr_emu;
  logic [7:0] emu_view;

  assign wr_ctrl = reg_req.wr && reg_req.addr == FES_ADDR_CTRL;
  assign wr_ebs = reg_req.wr && reg_req.addr == FES_ADDR_EBS;
  assign wr_emu = reg_req.wr && reg_req.addr == FES_ADDR_EMU;
  assign soft_write_enable = flash_control_reg_ff[FES_CTL_SWE];
  assign pe_active = flash_control_reg_ff[FES_CTL_PROG] | flash_control_reg_ff[FES_CTL_ERASE];
  assign emu_mode_ok = op_mode >= 3'h5 && op_mode <= 3'h7;
  assign emu_map_enable = emu_bits_ff[2] & emu_mode_ok;
  assign protect_all = emu_map_enable | flash_error_flag_ff;

  // Flash control: soft enable only with pin high, cleared in standby
  always_ff @(posedge clk) begin
    if (!rst_n || hw_standby || sw_standby || !write_enable_pin) begin
      flash_control_reg_ff <= FES_CTL_RST;
    end else if (wr_ctrl && op_mode != FES_MODE_NOPROG) begin
      flash_control_reg_ff <= {1'b0, reg_req.wdata[6:0]};
    end
  end

  // Erase block select register
  always_ff @(posedge clk) begin
    if (!rst_n || hw_standby || sw_standby || !write_enable_pin || !soft_write_enable) begin
      erase_block_select_ff <= FES_EBS_RST;
    end else if (op_mode == FES_MODE_NOPROG) begin
      erase_block_select_ff <= FES_EBS_RST;
    end else if (wr_ebs) begin
      erase_block_select_ff <= reg_req.wdata;
    end
  end
  assign block_erase_bits = erase_block_select_ff;

  // Emulation control bits: kept through software standby
  always_ff @(posedge clk) begin
    if (!rst_n || hw_standby) begin
      emu_bits_ff <= 3'h0;
    end else if (wr_emu && emu_mode_ok) begin
      emu_bits_ff <= reg_req.wdata[3:1];
    end
  end

  // Error flag: clear wins, cleared only by reset, watchdog, pin reset, hardware standby
  always_ff @(posedge clk) begin
    if (!rst_n || evt.wdt_reset || evt.pin_reset || hw_standby) begin
      flash_error_flag_ff <= 1'b0;
    end else if (pe_active && ((evt.flash_read && flash_hit && !ram_hit)
        || evt.exception
        || evt.sleep
        || evt.bus_release)) begin
      flash_error_flag_ff <= 1'b1;
    end
  end

  // Address decode for the overlay and flash range
  always_comb begin
    ram_hit = emu_map_enable && cpu_addr[ABITS-1:12] == {(ABITS-12){1'b0}}
      && cpu_addr[11:10] == emu_bits_ff[1:0];
    flash_hit = cpu_addr <= ABITS'(FES_FLASH_TOP);
    mapped_addr = cpu_addr;
    if (ram_hit) begin
      mapped_addr = ABITS'(FES_RAM_BASE) | {{ABITS-10{1'b0}}, cpu_addr[9:0]};
    end
  end
  assign ram_overlay_hit = ram_hit;

  // Erase block decode of the current address
  always_comb begin
    block_sel = 8'h00;
    if (cpu_addr < ABITS'(FES_BLK4_BASE)) begin
      block_sel[cpu_addr[11:10]] = 1'b1;
    end else if (cpu_addr < ABITS'(FES_BLK5_BASE)) begin
      block_sel[4] = 1'b1;
    end else if (cpu_addr < ABITS'(FES_BLK6_BASE)) begin
      block_sel[5] = 1'b1;
    end else if (cpu_addr < ABITS'(FES_BLK7_BASE)) begin
      block_sel[6] = 1'b1;
    end else if (flash_hit) begin
      block_sel[7] = 1'b1;
    end
  end

  // Per-block erase permission
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_blk
      assign erase_allow[gi] = block_erase_bits[gi] & soft_write_enable & ~protect_all;
    end
  endgenerate
  assign program_allow = soft_write_enable & ~protect_all;

  // Read data, one cycle after the strobe
  assign emu_view = FES_EMU_FIXED | {4'h0, emu_map_enable, emu_bits_ff[1:0] & {2{emu_mode_ok}}, 1'b0};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        FES_ADDR_CTRL: reg_rdata_ff <= {write_enable_pin, flash_control_reg_ff[6:0]};
        FES_ADDR_EBS: reg_rdata_ff <= erase_block_select_ff;
        FES_ADDR_EMU: reg_rdata_ff <= emu_view;
        FES_ADDR_ERR: reg_rdata_ff <= FES_ERR_RST | {flash_error_flag_ff, 7'h00};
        default: reg_rdata_ff <= 8'h00;
      endcase
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end
  assign reg_rdata = reg_rdata_ff;
endmodule

/* File: fes_flash_ctrl_properties.sv */
// Checker for the flash control block ports.
// Assumes one clock and synchronous active-low reset.
module fes_flash_ctrl_properties import fes_pkg::*; #(
  parameter int ABITS = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire fes_pkg::fes_reg_req_s reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic write_enable_pin,
  input wire logic [2:0] op_mode,
  input wire logic [ABITS-1:0] cpu_addr,
  input wire logic [ABITS-1:0] mapped_addr,
  input wire logic ram_overlay_hit,
  input wire logic [7:0] block_sel,
  input wire logic [7:0] erase_allow,
  input wire logic program_allow
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_SMALL_BLOCKS: assert property (cpu_addr[23:12] == 0 |-> block_sel == 8'h01 << cpu_addr[11:10])
    else $error("small block decode wrong");
  AST_OUTSIDE_FLASH: assert property (cpu_addr > FES_FLASH_TOP |-> block_sel == 8'h00)
    else $error("block select outside flash");
  AST_PIN_LOW_NO_ERASE: assert property (!write_enable_pin [*2] |-> erase_allow == 8'h00)
    else $error("erase allowed with pin low");
  AST_STATUS_RESERVED: assert property (reg_req.rd && reg_req.addr == FES_ADDR_ERR |=> reg_rdata[6:0] == 7'h7f)
    else $error("status low bits not ones");
  AST_EMU_FIXED_ONES: assert property (reg_req.rd && reg_req.addr == FES_ADDR_EMU |=> (reg_rdata & 8'hf1) == 8'hf1)
    else $error("emulation fixed bits wrong");
  AST_EMU_MODE_ZERO: assert property (reg_req.rd && reg_req.addr == FES_ADDR_EMU && op_mode < 3'h5 |=> reg_rdata[3:1] == 0)
    else $error("emulation bits visible outside modes");
  AST_OVERLAY_PROTECT: assert property (ram_overlay_hit |-> !program_allow && erase_allow == 8'h00)
    else $error("flash writable under emulation");
  AST_OVERLAY_MAP: assert property (ram_overlay_hit |-> cpu_addr[23:12] == 0 && mapped_addr == {14'h3ffc, cpu_addr[9:0]})
    else $error("overlay mapping wrong");
  AST_NO_HIT_PASS: assert property (!ram_overlay_hit |-> mapped_addr == cpu_addr)
    else $error("address altered without overlay");
  // Main scenarios
  cover property (ram_overlay_hit);
  cover property (erase_allow != 8'h00);
  cover property (reg_req.rd ##1 reg_rdata[7]);
endmodule
bind fes_flash_ctrl fes_flash_ctrl_properties #(.ABITS(ABITS)) u_chk (.*);

/* File: fes_pkg.sv */
// Package for the flash erase-select, RAM emulation and error flag block.
// Assumes a byte-wide register port with word-aligned register slots.
package fes_pkg;
  // Register byte addresses
  localparam logic [7:0] FES_ADDR_CTRL = 8'h00;
  localparam logic [7:0] FES_ADDR_EBS = 8'h04;
  localparam logic [7:0] FES_ADDR_EMU = 8'h08;
  localparam logic [7:0] FES_ADDR_ERR = 8'h0c;
  // Flash control register fields
  localparam int FES_CTL_PIN = 7;
  localparam int FES_CTL_SWE = 6;
  localparam int FES_CTL_ERASE = 1;
  localparam int FES_CTL_PROG = 0;
  // Emulation control fields
  localparam int FES_EMU_EN = 3;
  localparam logic [7:0] FES_EMU_FIXED = 8'hf1;
  localparam logic [7:0] FES_EMU_RST = 8'hf1;
  // Error status
  localparam int FES_ERR_FLAG = 7;
  localparam logic [7:0] FES_ERR_RST = 8'h7f;
  localparam logic [7:0] FES_EBS_RST = 8'h00;
  localparam logic [7:0] FES_CTL_RST = 8'h00;
  // Address map
  localparam logic [23:0] FES_RAM_BASE = 24'hfff000;
  localparam logic [23:0] FES_FLASH_TOP = 24'h01ffff;
  localparam logic [23:0] FES_BLK4_BASE = 24'h001000;
  localparam logic [23:0] FES_BLK5_BASE = 24'h008000;
  localparam logic [23:0] FES_BLK6_BASE = 24'h010000;
  localparam logic [23:0] FES_BLK7_BASE = 24'h018000;
  localparam logic [2:0] FES_MODE_NOPROG = 3'h6;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fes_reg_req_s;

  typedef struct packed {
    logic flash_read;
    logic exception;
    logic sleep;
    logic bus_release;
    logic wdt_reset;
    logic pin_reset;
  } fes_event_s;
endpackage

/* File: tb_top.sv */
// Bench for the flash control block.
// Assumes the cpu model and a bound checker.
module tb_top;
  import fes_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, pin, hws, sws, go;
  logic [2:0] mode;
  logic [5:0] kind;
  logic [23:0] a, ca, ma;
  logic [7:0] rdat, bsel, eal;
  logic hit, pal;
  fes_reg_req_s req;
  fes_event_s evt;
  int fail_count = 0, cmp_count = 0;
  fes_cpu_model i_cpu (.clk(clk), .go(go), .addr(a), .kind(kind), .cpu_addr(ca), .evt(evt));
  fes_flash_ctrl i_dut (.clk(clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdat), .write_enable_pin(pin),
    .op_mode(mode), .hw_standby(hws), .sw_standby(sws), .evt(evt), .cpu_addr(ca), .mapped_addr(ma),
    .ram_overlay_hit(hit), .block_sel(bsel), .erase_allow(eal), .program_allow(pal));
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] ad, logic [7:0] d);
    @(posedge clk) req <= '{ad, d, 1'b1, 1'b0};
    @(posedge clk) req.wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] ad, logic [7:0] e);
    @(posedge clk) req <= '{ad, 8'h00, 1'b0, 1'b1};
    @(posedge clk) req.rd <= 1'b0;
    #1 chk(rdat, e);
  endtask
  task automatic ev(logic [5:0] k);
    @(posedge clk) {go, kind} <= {1'b1, k};
    @(posedge clk) go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_ebs;
    wr(FES_ADDR_EBS, 8'h01); rd(FES_ADDR_EBS, 8'h00);
    // Block 2 selected alone and its erase permission checked
    wr(FES_ADDR_CTRL, 8'h40); wr(FES_ADDR_EBS, 8'h04); rd(FES_ADDR_EBS, 8'h04);
    a <= 24'h000a00; ev(6'h00); chk(eal, 8'h04);
    // Erase select held at zero while in mode 6
    mode <= 3'h6; wr(FES_ADDR_EBS, 8'h02); rd(FES_ADDR_EBS, 8'h00);
    mode <= 3'h5; wr(FES_ADDR_EBS, 8'h04); pin <= 1'b0; rd(FES_ADDR_EBS, 8'h00);
    pin <= 1'b1; wr(FES_ADDR_CTRL, 8'h40); wr(FES_ADDR_EBS, 8'h08); sws <= 1'b1; rd(FES_ADDR_EBS, 8'h00);
    sws <= 1'b0; // Software clears selection when idle
  endtask
  task automatic t_emu;
    // On-chip RAM taken as enabled before emulation
    wr(FES_ADDR_EMU, 8'h0e); rd(FES_ADDR_EMU, 8'hff);
    a <= 24'h000c10; ev(6'h00); chk({hit, pal, ma}, {2'b10, 24'hfff010});
    sws <= 1'b1; rd(FES_ADDR_EMU, 8'hff); sws <= 1'b0;
    hws <= 1'b1; @(posedge clk); hws <= 1'b0; rd(FES_ADDR_EMU, 8'hf1);
    mode <= 3'h4; rd(FES_ADDR_EMU, 8'hf1); mode <= 3'h5;
    wr(FES_ADDR_EMU, 8'h00);
  endtask
  task automatic t_err;
    wr(FES_ADDR_CTRL, 8'h41); a <= 24'h000100;
    for (int i = 2; i < 6; i++) begin
      ev(6'h01 << i); rd(FES_ADDR_ERR, 8'hff); chk({pal, eal}, 9'h000);
      ev(6'h01 << (i & 1)); rd(FES_ADDR_ERR, 8'h7f);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    #200000 fail_count++;
    final_report;
  end
  initial begin
    {rst_n, pin, hws, sws, go, kind, a, req} = '0;
    mode = 3'h5;
    pin = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(FES_ADDR_EMU, 8'hf1); rd(FES_ADDR_ERR, 8'h7f);
    t_ebs;
    t_emu;
    t_err;
    final_report;
  end
endmodule
